/* File: src/mrx_receiver.sv */
// Manchester receive path: carrier sense, clock recovery, decode, collision
// What this block does
// - Lock only after a 1010 preamble
// - Pulses under 20 ns are noise
// - Low pulse over 45 ns raises carrier
// - Idle oscillator locks to transmit clock
// - First zero halts, second zero restarts
// - Oscillator at four times bit rate
// - Strobe data at quarter bit
// - Correct phase by tenth of error
// - Carrier drops about 155 ns after last rise
// - Sample carrier at three-quarter bit
// - Carrier sense falls with clock rise, or at once if carrier is lost before lock
// - Hold carrier sense off 120 ns
// - Outputs enabled in bit cell five
// - Data idles high, undefined at acquisition
// - Sampled bit appears one clock later
// - Collision flag held 160 ns after rise
// - Ready within 10 ms of reset
// - Transmit clock is the 250 MHz clock over 24
`timescale 1ns/1ps
module mrx_receiver
  import mrx_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Line inputs, high means positive differential
  input wire logic rx_line,
  input wire logic collision_line,
  // Controller side
  output logic transmit_bit_clock,
  output logic recovered_clock,
  output logic recovered_data,
  output logic carrier_sense_out,
  output logic collision_flag_out,
  output logic receiver_ready
);
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  rx_state_e st_q, st_d;
  logic [PH_W-1:0] div_q, div_d;       // 250 MHz to 40 MHz tick divider
  logic [PH_W-1:0] tdiv_q, tdiv_d;     // Transmit clock divider
  logic [1:0] ph_q, ph_d;              // Quarter-bit phase
  logic [PH_W-1:0] low_q, low_d;       // Width of current low pulse
  logic [PH_W-1:0] off_q, off_d;       // Time since last rise while carrier
  logic [PH_W-1:0] hold_q, hold_d;
  logic [PH_W-1:0] col_q, col_d;
  logic [CNT_W-1:0] lock_q, lock_d;
  logic [2:0] zeros_q, zeros_d;
  logic [2:0] bitn_q, bitn_d;
  logic icarr_q, icarr_d;
  logic strobe_q, strobe_d;            // Internal strobe clock level
  logic carr_s_q, carr_s_d;
  logic rclk_q, rclk_d, rdata_q, rdata_d, crs_q, crs_d;
  logic transmit_bit_clock_q, transmit_bit_clock_d, collision_flag_out_q, collision_flag_out_d, rdy_q, rdy_d;
  logic line_q, col_line_q;
  logic signed [PH_W:0] err_q, err_d;  // Last measured phase error, 250 MHz cycles
  logic tick, rise, fall, col_rise, bit_strobe;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  rx_bit_s fifo_in, fifo_out;

  // Last quarter runs one cycle long so four ticks span a whole cell without drift
  assign tick = (div_q == PH_W'(OSC_DIV - 1) + PH_W'(&ph_q));
  assign rise = rx_line && !line_q;
  assign fall = !rx_line && line_q;
  assign col_rise = collision_line && !col_line_q;
  assign bit_strobe = tick && ph_q == PH_QUARTER && st_q == ST_TRACK;

  always_comb begin
    st_d = st_q;
    div_d = tick ? '0 : div_q + 1'b1;
    tdiv_d = (tdiv_q == PH_W'(TX_DIV - 1)) ? '0 : tdiv_q + 1'b1;
    transmit_bit_clock_d = (tdiv_q == PH_W'(TX_DIV - 1)) ? ~transmit_bit_clock_q : transmit_bit_clock_q;
    ph_d = tick ? ph_q + 1'b1 : ph_q;
    low_d = rx_line ? '0 : ((low_q == '1) ? low_q : low_q + 1'b1);
    off_d = rise ? '0 : ((off_q == '1) ? off_q : off_q + 1'b1);
    hold_d = (hold_q != '0) ? hold_q - 1'b1 : hold_q;
    col_d = col_rise ? PH_W'(COLLISION_FLAG_OUT_HOLD_CYC) : ((col_q != '0) ? col_q - 1'b1 : col_q);
    collision_flag_out_d = (col_q != '0) || col_rise;
    lock_d = (lock_q != '0) ? lock_q - 1'b1 : lock_q;
    rdy_d = (lock_q == '0);
    zeros_d = zeros_q;
    bitn_d = bitn_q;
    icarr_d = icarr_q;
    strobe_d = strobe_q;
    carr_s_d = carr_s_q;
    rclk_d = rclk_q;
    rdata_d = rdata_q;
    crs_d = crs_q;
    err_d = err_q;
    fifo_in_valid = 1'b0;
    fifo_in = '{data: line_q, last: 1'b0};
    // Noise shorter than the qualify window never reaches the counter limit
    if (!icarr_q && low_q == PH_W'(CARRIER_CYC) && low_q > PH_W'(NOISE_CYC)) begin
      icarr_d = 1'b1;
    end else if (icarr_q && rx_line && off_q == PH_W'(CARR_OFF_CYC)) begin
      icarr_d = 1'b0;
    end
    if (tick) begin
      strobe_d = (ph_q == PH_QUARTER) || (ph_q == PH_CENTRE);
    end
    case (st_q)
      ST_IDLE: begin
        // Phase follows the transmit clock while idle
        if (tdiv_q == PH_W'(TX_DIV - 1) && transmit_bit_clock_q) begin
          div_d = '0;
          ph_d = PH_QUARTER;
        end
        rdata_d = 1'b1;
        if (icarr_q && hold_q == '0) begin
          crs_d = 1'b1;
          zeros_d = '0;
          st_d = ST_WAIT_ZERO;
        end
      end
      ST_WAIT_ZERO: begin
        if (fall) begin
          // First zero stops the oscillator with the strobe high
          zeros_d = zeros_q + 1'b1;
          strobe_d = 1'b1;
          st_d = ST_HALT;
        end else if (!icarr_q) begin
          st_d = ST_HOLDOFF;
        end
      end
      ST_HALT: begin
        div_d = '0;
        ph_d = PH_QUARTER;
        strobe_d = 1'b1;
        if (fall && off_q > PH_W'(BIT_CYC / 2)) begin
          // Second zero after a one: 1010 seen; starting at the three-quarter
          // phase puts the next strobe a quarter into the following cell
          zeros_d = zeros_q + 1'b1;
          if (zeros_q + 1'b1 == ACQ_ZEROS) begin
            ph_d = PH_THREEQ;
            bitn_d = 3'h4;
            err_d = '0;
            st_d = ST_TRACK;
          end
        end else if (!icarr_q) begin
          st_d = ST_HOLDOFF;
        end
      end
      ST_TRACK: begin
        // Centre transition: measure the error, apply a tenth of the one from the previous transition
        if ((rise || fall) && ph_q == PH_CENTRE) begin
          err_d = $signed({1'b0, div_q}) - (PH_W+1)'(OSC_DIV / 2);
          div_d = div_q - PH_W'((err_q + 1) / CORR_DEN);
        end
        if (tick && ph_q == PH_THREEQ) begin
          carr_s_d = icarr_q;
        end
        if (bit_strobe) begin
          fifo_in_valid = (bitn_q >= FIRST_OUT_BIT - 1'b1);
          // A one shows low in its first half
          fifo_in = '{data: !line_q, last: !carr_s_q};
          bitn_d = (bitn_q == FIRST_OUT_BIT) ? bitn_q : bitn_q + 1'b1;
          if (!carr_s_q) begin
            st_d = ST_HOLDOFF;
          end
        end
        if (tick && ph_q == PH_THREEQ) begin
          rclk_d = 1'b0;
        end
      end
      ST_HOLDOFF: begin
        if (tick && ph_q == PH_THREEQ) begin
          rclk_d = 1'b0;
        end
        if (!crs_q && hold_q == '0 && !icarr_q) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Draining the FIFO is paced by the recovered clock rise
    // Keeps draining after the end of message so the last bit leaves too
    fifo_out_ready = tick && ph_q == PH_QUARTER && fifo_out_valid &&
      (st_q == ST_TRACK || st_q == ST_HOLDOFF);
    if (fifo_out_ready) begin
      rclk_d = 1'b1;
      rdata_d = fifo_out.data;
      if (fifo_out.last) begin
        crs_d = 1'b0;
        hold_d = PH_W'(HOLDOFF_CYC);
      end
    end else if (st_q == ST_HOLDOFF && !fifo_out_valid && crs_q) begin
      crs_d = 1'b0;
      hold_d = PH_W'(HOLDOFF_CYC);
    end
  end

  mrx_fifo #(
    .WIDTH($bits(rx_bit_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n_q),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_IDLE;
      div_q <= '0;
      tdiv_q <= '0;
      ph_q <= PH_QUARTER;
      low_q <= '0;
      off_q <= '0;
      hold_q <= '0;
      col_q <= '0;
      lock_q <= CNT_W'(LOCK_CYC);
      zeros_q <= '0;
      bitn_q <= '0;
      icarr_q <= 1'b0;
      strobe_q <= 1'b0;
      carr_s_q <= 1'b0;
      rclk_q <= 1'b0;
      rdata_q <= 1'b1;
      crs_q <= 1'b0;
      transmit_bit_clock_q <= 1'b0;
      collision_flag_out_q <= 1'b0;
      rdy_q <= 1'b0;
      err_q <= '0;
      line_q <= 1'b1;
      col_line_q <= 1'b0;
    end else begin
      st_q <= st_d;
      div_q <= div_d;
      tdiv_q <= tdiv_d;
      ph_q <= ph_d;
      low_q <= low_d;
      off_q <= off_d;
      hold_q <= hold_d;
      col_q <= col_d;
      lock_q <= lock_d;
      zeros_q <= zeros_d;
      bitn_q <= bitn_d;
      icarr_q <= icarr_d;
      strobe_q <= strobe_d;
      carr_s_q <= carr_s_d;
      rclk_q <= rclk_d;
      rdata_q <= rdata_d;
      crs_q <= crs_d;
      transmit_bit_clock_q <= transmit_bit_clock_d;
      collision_flag_out_q <= collision_flag_out_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
      line_q <= rx_line;
      col_line_q <= collision_line;
    end
  end

  assign transmit_bit_clock = transmit_bit_clock_q;
  assign recovered_clock = rclk_q;
  assign recovered_data = rdata_q;
  assign carrier_sense_out = crs_q;
  assign collision_flag_out = collision_flag_out_q;
  assign receiver_ready = rdy_q;
endmodule : mrx_receiver

/* File: src/mrx_pkg.sv */
// Package: constants, states and carriers for the Manchester receive block
package mrx_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CLK_PS = 4000;
  // Times in ns as printed
  localparam int NOISE_NS = 20;
  localparam int CARRIER_NS = 45;
  localparam int CARR_OFF_NS = 155;
  localparam int HOLDOFF_NS = 120;
  localparam int COLLISION_FLAG_OUT_HOLD_NS = 160;
  localparam int BIT_NS = 100;
  localparam int LOCK_MS = 10;
  // Cycle counts derived from the 250 MHz clock (least times round up)
  localparam int NOISE_CYC = (NOISE_NS * CLK_MHZ + 999) / 1000;
  localparam int CARRIER_CYC = (CARRIER_NS * CLK_MHZ + 999) / 1000;
  localparam int CARR_OFF_CYC = (CARR_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLDOFF_CYC = (HOLDOFF_NS * CLK_MHZ + 999) / 1000;
  localparam int COLLISION_FLAG_OUT_HOLD_CYC = (COLLISION_FLAG_OUT_HOLD_NS * CLK_MHZ) / 1000;
  localparam int BIT_CYC = (BIT_NS * CLK_MHZ) / 1000;
  localparam int LOCK_CYC_DEF = LOCK_MS * 1000 * CLK_MHZ;
  localparam int OSC_DIV = BIT_CYC / 4;
  localparam int TX_DIV = BIT_CYC / 2;
  // Phase positions inside a bit cell, in 40 MHz ticks
  localparam logic [1:0] PH_QUARTER = 2'h0;
  localparam logic [1:0] PH_CENTRE = 2'h1;
  localparam logic [1:0] PH_THREEQ = 2'h2;
  localparam int CORR_DEN = 10;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 24;
  localparam int PH_W = 8;
  localparam logic [2:0] ACQ_ZEROS = 3'h2;
  localparam logic [2:0] FIRST_OUT_BIT = 3'h5;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT_ZERO = 5'h02,
    ST_HALT = 5'h04,
    ST_TRACK = 5'h08,
    ST_HOLDOFF = 5'h10
  } rx_state_e;

  typedef struct packed {
    logic data;
    logic last;
  } rx_bit_s;
endpackage : mrx_pkg

/* File: src/mrx_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mrx_fifo
  import mrx_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Read side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic do_wr, do_rd;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    if (do_wr) begin
      mem_d[wp_q] = in_data;
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    end
    if (do_rd) begin
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
    end
    if (do_wr && !do_rd) begin
      cnt_d = cnt_q + 1'b1;
    end else if (do_rd && !do_wr) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : mrx_fifo

/* File: tb/mrx_chk.sv */
// Port checker for the Manchester receiver, bound to its top module
`timescale 1ns/1ps
module mrx_chk
  import mrx_pkg::*;
#(
  parameter int LOCK_CYC = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Line inputs
  input wire logic rx_line,
  input wire logic collision_line,
  // Controller side
  input wire logic transmit_bit_clock,
  input wire logic recovered_clock,
  input wire logic recovered_data,
  input wire logic carrier_sense_out,
  input wire logic collision_flag_out,
  input wire logic receiver_ready
);
  // Saturating counters, all but up_q parked high at reset so idle checks hold at once
  int off_q;
  int collision_flag_out_q;
  int rc_q;
  int up_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      off_q <= 1000;
      collision_flag_out_q <= 1000;
      rc_q <= 1000;
      up_q <= 0;
    end else begin
      off_q <= carrier_sense_out ? 0 : (off_q < 1000 ? off_q + 1 : off_q);
      collision_flag_out_q <= $rose(collision_line) ? 0 : (collision_flag_out_q < 1000 ? collision_flag_out_q + 1 : collision_flag_out_q);
      rc_q <= $rose(recovered_clock) ? 0 : (rc_q < 1000 ? rc_q + 1 : rc_q);
      up_q <= up_q < 1000 ? up_q + 1 : up_q;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence low_run_s;
    !$past(rx_line, 3) && !$past(rx_line, 8) && !$past(rx_line, 12);
  endsequence
  sequence collision_flag_out_edge_s;
    $rose(collision_line);
  endsequence
  sequence rc_edge_s;
    $rose(recovered_clock);
  endsequence
  carrier_on_a: assert property ($rose(carrier_sense_out) |-> low_run_s)
    else $error("carrier sense rose without a long low pulse");
  holdoff_a: assert property ($rose(carrier_sense_out) |-> off_q >= HOLDOFF_CYC - 2)
    else $error("carrier sense rose inside its hold-off");
  cs_drop_a: assert property ($fell(carrier_sense_out) && rc_q < 30 |->
    recovered_clock && !$past(recovered_clock, 2))
    else $error("carrier sense fell away from a clock rise");
  collision_flag_out_rise_a: assert property (collision_flag_out_edge_s |-> ##[1:2] collision_flag_out)
    else $error("collision flag late");
  collision_flag_out_hold_a: assert property (collision_flag_out_q inside {[3:36]} |-> collision_flag_out)
    else $error("collision flag dropped early");
  collision_flag_out_drop_a: assert property (collision_flag_out_q > 44 |-> !collision_flag_out)
    else $error("collision flag held too long");
  idle_out_a: assert property (off_q > 100 |-> recovered_data && !recovered_clock)
    else $error("idle outputs wrong");
  rc_gate_a: assert property (rc_edge_s |-> $past(carrier_sense_out))
    else $error("recovered clock outside a message");
  rc_space_a: assert property (rc_edge_s |-> rc_q >= 20)
    else $error("recovered clock rises too close");
  rc_high_a: assert property (rc_edge_s |=> recovered_clock [*8])
    else $error("recovered clock high phase too short");
  tx_clock_a: assert property ($changed(transmit_bit_clock) |=>
    $stable(transmit_bit_clock) [*8])
    else $error("transmit clock half period too short");
  ready_late_a: assert property (up_q > LOCK_CYC + 8 |-> receiver_ready)
    else $error("receiver not ready in time");
  ready_early_a: assert property (receiver_ready |-> up_q >= LOCK_CYC - 1)
    else $error("receiver ready too soon");
endmodule : mrx_chk

bind mrx_receiver mrx_chk #(.LOCK_CYC(LOCK_CYC)) chk (
  .clk, .arst_n, .rx_line, .collision_line, .transmit_bit_clock, .recovered_clock,
  .recovered_data, .carrier_sense_out, .collision_flag_out, .receiver_ready
);

/* File: tb/mrx_ctrl_model.sv */
// Controller model: collects recovered bits of one message
`timescale 1ns/1ps
module mrx_ctrl_model (
  // Clock
  input wire logic clk,
  // Receive side of the block
  input wire logic recovered_clock,
  input wire logic recovered_data,
  input wire logic carrier_sense_out,
  // Collected bits
  output logic [31:0] got,
  output int n
);
  // Taken at the clock fall, mid-way between data updates
  always_ff @(posedge clk) begin
    if ($rose(carrier_sense_out)) begin
      n <= 0;
    end else if ($fell(recovered_clock) && n < 32) begin
      got[n] <= recovered_data;
      n <= n + 1;
    end
  end
endmodule : mrx_ctrl_model

/* File: tb/tb.sv */
// Testbench for the Manchester receiver
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [15:0] pay;
    logic [15:0] exp;
  } row_s;
  localparam row_s ROWS [4] = '{'{16'hffff, 16'hffff}, '{16'h0000, 16'h0000},
    '{16'ha5c3, 16'ha5c3}, '{16'h3c5a, 16'h3c5a}};
  logic clk, arst_n, rx_line, collision_line;
  logic transmit_bit_clock, recovered_clock, recovered_data;
  logic carrier_sense_out, collision_flag_out, receiver_ready;
  logic [31:0] got;
  logic tq;
  int n, t, failures, checks;
  always #2 clk = ~clk;
  mrx_receiver #(.LOCK_CYC(20)) dut (.clk, .arst_n, .rx_line, .collision_line,
    .transmit_bit_clock, .recovered_clock, .recovered_data, .carrier_sense_out,
    .collision_flag_out, .receiver_ready);
  mrx_ctrl_model ctrl (.clk, .recovered_clock, .recovered_data, .carrier_sense_out,
    .got, .n);
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic half(input logic v, input int c);
    rx_line <= v;
    repeat (c) @(posedge clk);
  endtask : half
  // Low half first for a one; the 13-cycle low clears the carrier filter
  task automatic frame(input logic [15:0] p);
    logic [19:0] b;
    b = {4'ha, p};
    for (int i = 19; i >= 0; i--) begin
      half(!b[i], 13);
      half(b[i], 12);
    end
    rx_line <= 1'b1;
  endtask : frame
  task automatic wait_idle;
    for (int i = 0; carrier_sense_out !== 1'b0; i++) begin
      if (i == 400) begin
        failures++;
        results();
      end
      @(posedge clk);
    end
  endtask : wait_idle
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    rx_line = 1'b1;
    collision_line = 1'b0;
    repeat (20) @(posedge clk);
    cmp(recovered_data, 1);
    cmp(carrier_sense_out, 0);
    arst_n <= 1'b1;
    repeat (31) @(posedge clk);
    cmp(receiver_ready, 1);
    foreach (ROWS[r]) begin
      frame(ROWS[r].pay);
      wait_idle();
      repeat (20) @(posedge clk);
      cmp(n >= 16, 1);
      for (int k = 0; k < 16; k++)
        cmp(got[k], ROWS[r].exp[15-k]);
      repeat (60) @(posedge clk);
    end
    half(1'b0, 4);
    half(1'b1, 10);
    half(1'b0, 9);
    half(1'b1, 30);
    cmp(carrier_sense_out, 0);
    t = 0;
    tq = transmit_bit_clock;
    for (int i = 0; i < 480; i++) begin
      @(posedge clk);
      if (transmit_bit_clock && !tq)
        t++;
      tq = transmit_bit_clock;
    end
    cmp(t, 20);
    for (int i = 0; i < 3; i++) begin
      collision_line <= 1'b1;
      repeat (3) @(posedge clk);
      cmp(collision_flag_out, 1);
      repeat (9) @(posedge clk);
      collision_line <= 1'b0;
      repeat (13) @(posedge clk);
    end
    repeat (10) @(posedge clk);
    cmp(collision_flag_out, 1);
    repeat (12) @(posedge clk);
    cmp(collision_flag_out, 0);
    results();
  end
endmodule : tb
